// ---- design/ddc_pkg.sv ----
/*
 * shared constants, sample and configuration types of the down-converter chain.
 * assumes a single processing clock; ports are sampled into it by the top module.
 */
package ddc_pkg;
    // ********************************
    // sizes and limits
    // ********************************
    localparam int DATA_W         = 16;
    localparam int NCO_W          = 32;
    localparam int POFF_W         = 16;
    localparam int NUM_IN         = 4;
    localparam int NUM_OUT        = 3;
    localparam int NUM_CHAN       = 6;
    localparam int CIC_ORDER      = 5;
    localparam int CIC_MAX_RATE   = 32;
    localparam int CIC_W          = 42;
    localparam int FIXED_STAGES   = 4;
    localparam int RCF_STAGES     = 3;
    localparam int RCF_TAPS       = 4;
    localparam int RCF_MAX_DEC    = 16;
    localparam int NONDECIMATING_COEF_FILTER_CLK_DIV   = 4;
    localparam int PLL_MAX_MHZ    = 200;
    localparam int PORT_MAX_MSPS  = 150;
    localparam int PAIR2_MAX_MSPS = 75;
    localparam int AGC_FRAC       = 8;

    // ********************************
    // reset values
    // ********************************
    localparam logic [15:0] GAIN_RESET = 16'h0100;
    localparam logic [15:0] LFSR_SEED  = 16'hACE1;

    localparam logic [15:0] SIN_TBL [16] = '{16'h0000, 16'h30FB, 16'h5A82, 16'h7641,
        16'h7FFF, 16'h7641, 16'h5A82, 16'h30FB, 16'h0000, 16'hCF05, 16'hA57E, 16'h89BF,
        16'h8001, 16'h89BF, 16'hA57E, 16'hCF05};

    typedef logic signed [DATA_W-1:0] samp_t;

    typedef struct packed {
        logic  v;
        samp_t i;
        samp_t q;
    } cplx_t;

    typedef struct packed {
        logic [NCO_W-1:0]                         freq;
        logic [POFF_W-1:0]                        phase_off;
        logic                                     phase_dither;
        logic                                     amp_dither;
        logic                                     mixer_bypass;
        logic                                     complex_in;
        logic [1:0]                               in_sel;
        logic [5:0]                               cic_rate;
        logic [FIXED_STAGES-1:0]                  fixed_bypass;
        logic [RCF_STAGES-1:0]                    rcf_bypass;
        logic [RCF_STAGES-1:0][4:0]               rcf_dec;
        logic [RCF_STAGES-1:0][RCF_TAPS-1:0][15:0] rcf_coef;
        logic                                     ihb_bypass;
        logic [2:0]                               route_src;
        logic [3:0]                               agc_tc;
        logic [15:0]                              agc_req;
        logic [4:0]                               out_bits;
    } chan_cfg_t;
endpackage

// ---- design/cic_if.sv ----
/*
 * carrier between the chain top and one fifth-order comb decimator.
 * assumes both ends run on the processing clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface cic_if;
    import ddc_pkg::*;
    cplx_t      in_s;
    logic [5:0] rate;
    cplx_t      out_s;
    modport src (output in_s, output rate, input out_s);
    modport dec (input in_s, input rate, output out_s);
endinterface
`default_nettype wire

// ---- design/fifth_order_comb_decimator.sv ----
/*
 * five integrators, decimate by rate, five combs, gain-normalising shift.
 * assumes rate is held stable while samples flow; rate 0 acts as 1.
 */
`timescale 1ns/1ns
`default_nettype none
module fifth_order_comb_decimator
    import ddc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    cic_if.dec        bus
);
    typedef logic signed [CIC_W-1:0] wide_t;

    typedef struct packed {
        wide_t [CIC_ORDER-1:0][1:0] integ;
        wide_t [CIC_ORDER-1:0][1:0] dly;
        logic  [5:0]                cnt;
        cplx_t                      res;
    } cic_st_t;

    cic_st_t s_q, s_d;

    // growth is rate^5; shift by 5*ceil(log2 rate) keeps the top bits
    function automatic int gain_shift(input logic [5:0] r);
        int b;
        b = 0;
        while (b < 6 && (7'd1 << b) < {1'b0, r}) begin
            b++;
        end
        return CIC_ORDER * b;
    endfunction

    always_comb begin
        wide_t [1:0] c;
        wide_t [1:0] x;
        logic  [5:0] last;
        s_d = s_q;
        c = '0;
        last = (bus.rate == 6'h00) ? 6'h00 : bus.rate - 6'h01;
        x[0] = wide_t'(bus.in_s.i);
        x[1] = wide_t'(bus.in_s.q);
        s_d.res.v = 1'b0;
        if (bus.in_s.v) begin
            for (int p = 0; p < 2; p++) begin
                s_d.integ[0][p] = s_q.integ[0][p] + x[p];
                for (int k = 1; k < CIC_ORDER; k++) begin
                    s_d.integ[k][p] = s_q.integ[k][p] + s_q.integ[k-1][p];
                end
            end
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt >= last) begin
                s_d.cnt = 6'h00;
                for (int p = 0; p < 2; p++) begin
                    c[p] = s_q.integ[CIC_ORDER-1][p];
                    for (int k = 0; k < CIC_ORDER; k++) begin
                        s_d.dly[k][p] = c[p];
                        c[p] = c[p] - s_q.dly[k][p];
                    end
                    c[p] = c[p] >>> gain_shift(bus.rate);
                end
                s_d.res = '{v: 1'b1, i: samp_t'(c[0]), q: samp_t'(c[1])};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.out_s = s_q.res;
endmodule
`default_nettype wire

// ---- design/ddc_chain.sv ----
/*
 * multichannel down-converter chain: port capture, mixer, comb decimator,
 * fixed and coefficient filters, interpolating half-band, gain control, output ports.
 * assumes clock is the multiplied processing clock and config ports are quasi-static.
 */
// Functional notes
// - 32-bit complex oscillator mixes real or complex input
// - 16-bit phase offset added to oscillator phase
// - separate phase and amplitude dither enables
// - mixer bypass passes port I/Q unchanged
// - comb decimator rate any integer 1 to 32
// - two FIR plus half-band pairs, each bypassable
// - first pair 150 MSPS, second pair 75 MSPS
// - first coefficient filter input at most clock/4
// - second coefficient filter decimates 1 to 16
// - channel coefficient filter decimates 1 to 16
// - final half-band interpolates by two
// - each port latched on own clock; A feeds PLL
// - back-end runs on processing clock, max 200 MHz
// - router feeds comb outputs to any chain
// - tandem channels, biphase combining at output
// - gain follows measured level toward requested level
// - programmable clipping and rounding of output width
// - four single ports or two paired ports
// - four-channel variant drops channels 4 and 5
// - three 16-bit output ports
`timescale 1ns/1ns
`default_nettype none
module ddc_chain
    import ddc_pkg::*;
#(
    parameter int CHANNELS    = NUM_CHAN,
    parameter int PRESENT     = NUM_CHAN,
    parameter int OUT_PORTS   = NUM_OUT
) (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic [NUM_IN-1:0]           in_clk,
    input  wire logic [NUM_IN-1:0][15:0]     in_data,
    input  wire logic                        pair_mode,
    input  wire chan_cfg_t [CHANNELS-1:0]    cfg,
    input  wire logic [OUT_PORTS-1:0]        biphase,
    output logic [OUT_PORTS-1:0]             out_valid,
    output logic [OUT_PORTS-1:0][15:0]       out_i,
    output logic [OUT_PORTS-1:0][15:0]       out_q,
    output logic [OUT_PORTS-1:0][2:0]        out_chan,
    output logic [CHANNELS-1:0]              rate_err
);
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [2:0]  clk_s;
        logic [15:0] d1;
        logic [15:0] d2;
        logic        v;
        logic [15:0] smp;
    } port_st_t;

    typedef struct packed {
        logic [NCO_W-1:0]                         acc;
        cplx_t                                    mix;
        samp_t [FIXED_STAGES-1:0][1:0]            h1;
        samp_t [FIXED_STAGES-1:0][1:0]            h2;
        logic  [FIXED_STAGES-1:0]                 ph;
        samp_t [RCF_STAGES-1:0][1:0][RCF_TAPS-2:0] tap;
        logic  [RCF_STAGES-1:0][3:0]              dcnt;
        logic  [2:0]                              gap;
        logic                                     err;
        samp_t [1:0]                              prev;
        cplx_t                                    pend;
        logic  [31:0]                             pwr;
        logic  [15:0]                             gain;
        cplx_t                                    res;
    } chan_st_t;

    typedef struct packed {
        cplx_t      o;
        logic [2:0] ch;
        cplx_t      held;
    } oport_st_t;

    typedef struct packed {
        logic [15:0]                   lfsr;
        port_st_t [NUM_IN-1:0]         port;
        chan_st_t [CHANNELS-1:0]       ch;
        oport_st_t [OUT_PORTS-1:0]     op;
    } st_t;

    st_t s_q, s_d;
    cplx_t [CHANNELS-1:0] cic_out;

    // ********************************
    // helpers
    // ********************************
    function automatic samp_t sat16(input logic signed [31:0] v);
        if (v > 32'sh00007FFF) return 16'sh7FFF;
        if (v < -32'sh00008000) return 16'sh8000;
        return samp_t'(v);
    endfunction

    function automatic samp_t mac4(input logic [RCF_TAPS-1:0][15:0] cf, input samp_t x,
                                   input samp_t [RCF_TAPS-2:0] t);
        logic signed [35:0] a;
        a = 36'(x * $signed(cf[0]));
        for (int k = 1; k < RCF_TAPS; k++) begin
            a = a + 36'(t[k-1] * $signed(cf[k]));
        end
        return sat16(32'(a >>> 15));
    endfunction

    // clip then round to the requested width; narrower words keep zeros below
    function automatic samp_t shape(input logic signed [31:0] v, input logic [4:0] bits);
        logic signed [31:0] r;
        int                 drop;
        drop = (bits == 5'd0 || bits > 5'd16) ? 0 : 16 - int'(bits);
        r = 32'(sat16(v));
        if (drop > 0) begin
            r = r + (32'sd1 <<< (drop - 1));
            r = (r >>> drop) <<< drop;
            // rounding past full scale falls back one step, low bits stay clear
            if (r > 32'sh00007FFF) begin
                r = r - (32'sd1 <<< drop);
            end
        end
        return sat16(r);
    endfunction

    // ********************************
    // parameter checks
    // ********************************
    if (CHANNELS != 2 * OUT_PORTS || CHANNELS > 8 || (PRESENT != 4 && PRESENT != 6)
        || PRESENT > CHANNELS) begin : g_bad_params
        $error("ddc_chain: unsupported channel or port count");
    end

    // ********************************
    // comb decimators and router taps
    // ********************************
    for (genvar c = 0; c < CHANNELS; c++) begin : g_cic
        cic_if bus ();
        assign bus.in_s = s_q.ch[c].mix;
        assign bus.rate = cfg[c].cic_rate;
        assign cic_out[c] = bus.out_s;
        fifth_order_comb_decimator u_cic (
            .clock (clock),
            .rst_n (rst_n),
            .bus   (bus)
        );
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        cplx_t              x;
        samp_t              xi;
        samp_t              xq;
        samp_t              cs;
        samp_t              sn;
        samp_t [1:0]        y;
        logic [15:0]        ph;
        logic signed [32:0] pi;
        logic signed [32:0] pq;
        logic [2:0]         src;
        logic [16:0]        mag;
        logic [4:0]         last;
        logic [1:0]         qsel;
        s_d = s_q;
        x = '0;
        y = '0;
        xi = '0;
        xq = '0;
        cs = '0;
        sn = '0;
        ph = '0;
        pi = '0;
        pq = '0;
        src = '0;
        mag = '0;
        last = '0;
        qsel = '0;
        s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};

        // each port caught on its own clock edge, seen through two flops
        for (int p = 0; p < NUM_IN; p++) begin
            s_d.port[p].clk_s = {s_q.port[p].clk_s[1:0], in_clk[p]};
            s_d.port[p].d1 = in_data[p];
            s_d.port[p].d2 = s_q.port[p].d1;
            s_d.port[p].v = s_q.port[p].clk_s[1] & ~s_q.port[p].clk_s[2]
                          & ~(pair_mode & p[0]);
            if (s_d.port[p].v) begin
                s_d.port[p].smp = s_q.port[p].d2;
            end
        end

        for (int c = 0; c < CHANNELS; c++) begin
            // mixer
            s_d.ch[c].mix.v = 1'b0;
            qsel = cfg[c].in_sel ^ 2'b01;
            if (s_q.port[cfg[c].in_sel].v && c < PRESENT) begin
                xi = samp_t'(s_q.port[cfg[c].in_sel].smp);
                xq = cfg[c].complex_in ? samp_t'(s_q.port[qsel].smp) : '0;
                s_d.ch[c].acc = s_q.ch[c].acc + cfg[c].freq;
                ph = s_q.ch[c].acc[NCO_W-1 -: 16] + cfg[c].phase_off;
                if (cfg[c].phase_dither) begin
                    ph = ph + {12'h000, s_q.lfsr[3:0]};
                end
                sn = samp_t'(SIN_TBL[ph[15:12]]);
                cs = samp_t'(SIN_TBL[4'(ph[15:12] + 4'h4)]);
                pi = 33'(xi * cs) + 33'(xq * sn);
                pq = 33'(xq * cs) - 33'(xi * sn);
                if (cfg[c].amp_dither) begin
                    pi = pi + 33'(s_q.lfsr[7:0]);
                    pq = pq + 33'(s_q.lfsr[15:8]);
                end
                if (cfg[c].mixer_bypass) begin
                    s_d.ch[c].mix = '{v: 1'b1, i: xi, q: xq};
                end else begin
                    s_d.ch[c].mix = '{v: 1'b1, i: sat16(32'(pi >>> 15)),
                                      q: sat16(32'(pq >>> 15))};
                end
            end

            // router: any chain may take any comb output
            src = (int'(cfg[c].route_src) < CHANNELS) ? cfg[c].route_src : 3'(c);
            x = cic_out[src];
            if (c >= PRESENT) begin
                x.v = 1'b0;
            end

            // fixed pairs: even stage 1-2-1 FIR, odd stage half-band by two;
            // the second pair sees half the first pair's rate unless stage 1 is bypassed
            for (int k = 0; k < FIXED_STAGES; k++) begin
                if (x.v && !cfg[c].fixed_bypass[k]) begin
                    y[0] = x.i;
                    y[1] = x.q;
                    for (int p = 0; p < 2; p++) begin
                        if (k % 2 == 0) begin
                            s_d.ch[c].h1[k][p] = y[p];
                            s_d.ch[c].h2[k][p] = s_q.ch[c].h1[k][p];
                            y[p] = samp_t'((18'(y[p]) + (18'(s_q.ch[c].h1[k][p]) <<< 1)
                                   + 18'(s_q.ch[c].h2[k][p])) >>> 2);
                        end else begin
                            s_d.ch[c].h1[k][p] = y[p];
                            y[p] = samp_t'((17'(y[p]) + 17'(s_q.ch[c].h1[k][p])) >>> 1);
                        end
                    end
                    if (k % 2 == 1) begin
                        s_d.ch[c].ph[k] = ~s_q.ch[c].ph[k];
                    end
                    x = '{v: (k % 2 == 0) || s_q.ch[c].ph[k], i: y[0], q: y[1]};
                end
            end

            // coefficient filters: stage 0 never decimates and is rate-limited
            if (s_q.ch[c].gap != 3'd0) begin
                s_d.ch[c].gap = s_q.ch[c].gap - 3'd1;
            end
            for (int r = 0; r < RCF_STAGES; r++) begin
                if (x.v && !cfg[c].rcf_bypass[r]) begin
                    if (r == 0) begin
                        if (s_q.ch[c].gap != 3'd0) begin
                            s_d.ch[c].err = 1'b1;
                        end
                        s_d.ch[c].gap = 3'(NONDECIMATING_COEF_FILTER_CLK_DIV - 1);
                    end
                    y[0] = mac4(cfg[c].rcf_coef[r], x.i, s_q.ch[c].tap[r][0]);
                    y[1] = mac4(cfg[c].rcf_coef[r], x.q, s_q.ch[c].tap[r][1]);
                    s_d.ch[c].tap[r][0] = {s_q.ch[c].tap[r][0][RCF_TAPS-3:0], x.i};
                    s_d.ch[c].tap[r][1] = {s_q.ch[c].tap[r][1][RCF_TAPS-3:0], x.q};
                    last = (r == 0 || cfg[c].rcf_dec[r] == 5'd0) ? 5'd0
                         : cfg[c].rcf_dec[r] - 5'd1;
                    if ({1'b0, s_q.ch[c].dcnt[r]} >= last) begin
                        s_d.ch[c].dcnt[r] = 4'h0;
                        x = '{v: 1'b1, i: y[0], q: y[1]};
                    end else begin
                        s_d.ch[c].dcnt[r] = s_q.ch[c].dcnt[r] + 4'h1;
                        x.v = 1'b0;
                    end
                end
            end

            // interpolate by two: midpoint now, the sample itself next cycle;
            // back-to-back input would drop a pending sample
            if (!cfg[c].ihb_bypass) begin
                s_d.ch[c].pend.v = 1'b0;
                if (x.v) begin
                    s_d.ch[c].prev = {x.q, x.i};
                    s_d.ch[c].pend = x;
                    x.i = samp_t'((17'(x.i) + 17'(s_q.ch[c].prev[0])) >>> 1);
                    x.q = samp_t'((17'(x.q) + 17'(s_q.ch[c].prev[1])) >>> 1);
                end else if (s_q.ch[c].pend.v) begin
                    x = s_q.ch[c].pend;
                end
            end

            // gain control: mean magnitude stands in for rms to avoid squaring
            s_d.ch[c].res.v = 1'b0;
            if (x.v) begin
                mag = 17'(x.i < 0 ? -x.i : x.i) + 17'(x.q < 0 ? -x.q : x.q);
                s_d.ch[c].pwr = s_q.ch[c].pwr - (s_q.ch[c].pwr >> cfg[c].agc_tc)
                              + {15'h0000, mag};
                if ((s_q.ch[c].pwr >> cfg[c].agc_tc) > {16'h0000, cfg[c].agc_req}) begin
                    if (s_q.ch[c].gain > 16'h0001) begin
                        s_d.ch[c].gain = s_q.ch[c].gain - 16'h0001;
                    end
                end else if (s_q.ch[c].gain != 16'hFFFF) begin
                    s_d.ch[c].gain = s_q.ch[c].gain + 16'h0001;
                end
                s_d.ch[c].res = '{v: 1'b1,
                    i: shape(32'(x.i * $signed({1'b0, s_q.ch[c].gain})) >>> AGC_FRAC,
                             cfg[c].out_bits),
                    q: shape(32'(x.q * $signed({1'b0, s_q.ch[c].gain})) >>> AGC_FRAC,
                             cfg[c].out_bits)};
            end
        end

        // output ports: channel pair 2k/2k+1, summed in biphase mode
        for (int k = 0; k < OUT_PORTS; k++) begin
            s_d.op[k].o.v = 1'b0;
            if (biphase[k]) begin
                if (s_q.ch[2*k].res.v) begin
                    s_d.op[k].held = s_q.ch[2*k].res;
                end
                // tandem halves come together; pair with the even half of this cycle
                if (s_q.ch[2*k+1].res.v && s_d.op[k].held.v) begin
                    s_d.op[k].o = '{v: 1'b1,
                        i: sat16(32'(s_d.op[k].held.i) + 32'(s_q.ch[2*k+1].res.i)),
                        q: sat16(32'(s_d.op[k].held.q) + 32'(s_q.ch[2*k+1].res.q))};
                    s_d.op[k].ch = 3'(2*k);
                    s_d.op[k].held.v = 1'b0;
                end
            end else if (s_q.ch[2*k].res.v) begin
                s_d.op[k].o = s_q.ch[2*k].res;
                s_d.op[k].ch = 3'(2*k);
                s_d.op[k].held = s_q.ch[2*k+1].res;
            end else if (s_q.op[k].held.v) begin
                s_d.op[k].o = s_q.op[k].held;
                s_d.op[k].ch = 3'(2*k+1);
                s_d.op[k].held = s_q.ch[2*k+1].res;
            end else if (s_q.ch[2*k+1].res.v) begin
                s_d.op[k].o = s_q.ch[2*k+1].res;
                s_d.op[k].ch = 3'(2*k+1);
            end
        end
    end

    // ********************************
    // registers (whole back-end on processing clock)
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.lfsr <= LFSR_SEED;
            for (int c = 0; c < CHANNELS; c++) begin
                s_q.ch[c].gain <= GAIN_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    for (genvar k = 0; k < OUT_PORTS; k++) begin : g_out
        assign out_valid[k] = s_q.op[k].o.v;
        assign out_i[k] = s_q.op[k].o.i;
        assign out_q[k] = s_q.op[k].o.q;
        assign out_chan[k] = s_q.op[k].ch;
    end
    for (genvar c = 0; c < CHANNELS; c++) begin : g_err
        assign rate_err[c] = s_q.ch[c].err;
    end
endmodule
`default_nettype wire

// ---- dv/adc_model.sv ----
/* adc source: one sample clock pulse per period and lfsr data on all ports.
   assumes period is given in processing clocks and is at least 3. */
`timescale 1ns/1ns
`default_nettype none
module adc_model (
    input  wire logic        clock,
    input  wire logic        run,
    input  wire logic [31:0] period,
    output logic [3:0]       in_clk,
    output logic [3:0][15:0] in_data
);
    // ********
    // source
    // ********
    int ph = 0;
    logic [31:0] lfsr = 32'h0D86E6ED;
    initial in_clk = 4'h0;
    initial in_data = '0;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // clock stands still outside bursts; data moves mid-period, away from the rise
    always @(posedge clock) begin
        ph = (run || ph != 0) ? (ph + 1) % period : 0;
        in_clk <= {4{ph == 1}};
        if (ph == period / 2 + 1) begin
            lfsr = lfsr_next(lfsr);
            in_data <= {lfsr[15:0], lfsr[31:16], ~lfsr[15:0], ~lfsr[31:16]};
        end
    end
endmodule
`default_nettype wire

// ---- dv/ddc_chain_properties.sv ----
/* port checker for the down-converter chain.
   assumes one clock domain; bound to every ddc_chain instance. */
`timescale 1ns/1ns
`default_nettype none
module ddc_chain_checker
    import ddc_pkg::*;
#(parameter int CHANNELS = NUM_CHAN, parameter int PRESENT = NUM_CHAN,
  parameter int OUT_PORTS = NUM_OUT) (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic [NUM_IN-1:0]        in_clk,
    input wire chan_cfg_t [CHANNELS-1:0] cfg,
    input wire logic [OUT_PORTS-1:0]     biphase,
    input wire logic [OUT_PORTS-1:0]     out_valid,
    input wire logic [OUT_PORTS-1:0][15:0] out_i,
    input wire logic [OUT_PORTS-1:0][15:0] out_q,
    input wire logic [OUT_PORTS-1:0][2:0]  out_chan,
    input wire logic [CHANNELS-1:0]      rate_err
);
    // ********
    // checks
    // ********
    logic [3:0] idle_q;
    // cycles since any port clock was last high, saturating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) idle_q <= 4'hF;
        else idle_q <= (|in_clk) ? 4'h0 : idle_q + 4'(idle_q != 4'hF);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_err_sticky: assert property (rate_err[0] |=> rate_err[0])
        else $error("rate error flag dropped");
    a_err_clear: assert property ($rose(rst_n) |-> rate_err == '0)
        else $error("rate error set after reset");
    a_reset_quiet: assert property ($rose(rst_n) |-> out_valid == '0)
        else $error("output valid right after reset");
    a_port_chan: assert property (out_valid[0] |-> out_chan[0] <= 3'h1)
        else $error("foreign channel on port 0");
    a_biphase_even: assert property (out_valid[0] && biphase[0] |-> out_chan[0] == 3'h0)
        else $error("combined sample not tagged even");
    a_absent_silent: assert property (!(PRESENT <= 4 && out_valid[2]))
        else $error("absent channel produced output");
    a_out_latency: assert property (out_valid[0] |-> idle_q <= 4'hC)
        else $error("output without recent input");
    a_round_low: assert property (out_valid[0] && !biphase[0] && cfg[0].out_bits == 5'd12
        && cfg[1].out_bits == 5'd12 |-> out_i[0][3:0] == 4'h0 && out_q[0][3:0] == 4'h0)
        else $error("low bits not cleared");
endmodule
bind ddc_chain ddc_chain_checker #(.CHANNELS(CHANNELS), .PRESENT(PRESENT),
    .OUT_PORTS(OUT_PORTS)) chk_u (.clock(clock), .rst_n(rst_n), .in_clk(in_clk), .cfg(cfg),
    .biphase(biphase), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
    .out_chan(out_chan), .rate_err(rate_err));
`default_nettype wire

// ---- dv/tb.sv ----
/* self-checking bench: counts even-channel outputs against decimation ratios.
   assumes adc_model clocks all ports alike; channel 2 reads port b, the rest port a. */
`timescale 1ns/1ns
`default_nettype none
module tb
    import ddc_pkg::*;
;
    // ********
    // bench
    // ********
    logic clock, rst_n, run, prev_a, pair_mode;
    logic [2:0] biphase, out_valid;
    logic [3:0] in_clk;
    logic [3:0][15:0] in_data;
    logic [2:0][15:0] out_i, out_q;
    logic [2:0][2:0] out_chan;
    logic [5:0] rate_err;
    chan_cfg_t [5:0] cfg;
    int period, n_in, mismatches, n_compared;
    int cnt[8];
    initial begin clock = 1'b0; forever #50 clock = ~clock; end
    adc_model src_u (.clock(clock), .run(run), .period(period), .in_clk(in_clk),
        .in_data(in_data));
    ddc_chain #(.PRESENT(4)) dut_u (.clock(clock), .rst_n(rst_n), .in_clk(in_clk),
        .in_data(in_data), .pair_mode(pair_mode), .cfg(cfg), .biphase(biphase),
        .out_valid(out_valid), .out_i(out_i), .out_q(out_q), .out_chan(out_chan),
        .rate_err(rate_err));
    // model: count port a edges and even-channel samples; odd ones may be dropped
    always @(posedge clock) begin
        prev_a <= in_clk[0];
        if (in_clk[0] && !prev_a) n_in++;
        for (int k = 0; k < 3; k++)
            if (out_valid[k] === 1'b1 && out_chan[k][0] === 1'b0) cnt[out_chan[k]]++;
    end
    task automatic chk(input logic [31:0] got, input int exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic phase(input int rate, input logic [3:0] fb, input logic interpolating_halfband,
        input logic bp, input int per, input int mul, input int div);
        rst_n <= 1'b0;
        for (int c = 0; c < 6; c++) begin
            cfg[c].cic_rate <= 6'(rate);
            cfg[c].fixed_bypass <= fb;
            cfg[c].ihb_bypass <= interpolating_halfband;
        end
        biphase <= {2'b00, bp};
        period <= per;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        n_in = 0;
        cnt = '{default: 0};
        @(posedge clock);
        run <= 1'b1;
        for (int i = 0; i < 2000 && n_in < 64; i++) @(posedge clock);
        run <= 1'b0;
        repeat (60) @(posedge clock);
        chk(cnt[0], n_in * mul / div);
        chk(cnt[2], pair_mode ? 0 : n_in * mul / div);
        chk(cnt[4], 0);
        chk(rate_err[3:0], per < 4 ? 4'hF : 4'h0);
    endtask
    initial begin
        rst_n = 1'b0; run = 1'b0; period = 8; biphase = 3'h0; cfg = '0;
        mismatches = 0; n_compared = 0; n_in = 0; pair_mode = 1'b0;
        // coefficient filter left in so the rate check has something to watch
        for (int c = 0; c < 6; c++) begin
            cfg[c].mixer_bypass = 1'b1;
            cfg[c].rcf_bypass = 3'h6;
            cfg[c].rcf_coef[0][0] = 16'h7FFF;
            cfg[c].route_src = 3'h7;
            cfg[c].out_bits = 5'h0C;
            cfg[c].agc_req = 16'h0100;
        end
        // odd port feeds channel 2, so paired mode must silence it
        cfg[2].in_sel = 2'h1;
        phase(1, 4'hF, 1'b1, 1'b0, 8, 1, 1);
        phase(2, 4'hF, 1'b1, 1'b0, 8, 1, 2);
        phase(32, 4'hF, 1'b1, 1'b0, 8, 1, 32);
        phase(1, 4'h5, 1'b1, 1'b0, 8, 1, 4);
        phase(4, 4'hF, 1'b0, 1'b0, 8, 2, 4);
        phase(1, 4'hF, 1'b1, 1'b1, 8, 1, 1);
        phase(1, 4'hF, 1'b1, 1'b0, 3, 1, 1);
        pair_mode <= 1'b1;
        phase(1, 4'hF, 1'b1, 1'b0, 8, 1, 1);
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        close_out;
    end
endmodule
`default_nettype wire
